/* design/sar_adc_ctrl.sv */
// Successive-approximation converter control: registers, sequencer and results
`timescale 1ns/1ps
`default_nettype none

module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [19:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       bit_wr_in,
  input  wire logic [2:0] bit_sel_in,
  input  wire logic       bit_val_in,
  input  wire logic       rd_in,
  input  wire logic       comp_in,
  output logic      [7:0] rdata_out,
  output logic            conversion_end_irq_out,
  output logic            sample_hold_out,
  output logic      [9:0] tap_select_out,
  output logic      [2:0] channel_select_out,
  output logic            comparator_enable_out,
  output logic            converting_out
);

  typedef struct packed {
    phase_t     phase;
    logic       start;
    logic       cmp_en;
    logic [1:0] fr;
    logic       lv0;
    logic       res8;
    logic [2:0] chan;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [9:0] sar;
    logic [3:0] bit_pos;
    logic [2:0] div_cnt;
    logic [4:0] step_cnt;
    logic       pend;
    logic [7:0] pend_high;
    logic [7:0] pend_low;
    logic       irq;
    logic       hold;
    logic [7:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] sel, input logic val);
    logic [7:0] r;
    r = cur;
    r[sel] = val;
    return r;
  endfunction

  function automatic logic [2:0] div_reload(input logic [1:0] fr);
    case (fr)
      2'h0: return 3'h7;
      2'h1: return 3'h3;
      2'h2: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  logic [7:0] mode0_cur;
  logic [7:0] chan_cur;
  logic       any_wr;
  logic       mode0_wr;
  logic       chan_wr;
  logic       mode2_wr;
  logic       rd_result;
  logic       tick;
  logic       end_now;
  logic [7:0] wval_mode0;
  logic [7:0] wval_chan;
  logic [7:0] wval_mode2;
  logic [7:0] new_high;
  logic [7:0] new_low;

  assign mode0_cur  = {s.start, 2'b00, s.fr, 1'b0, s.lv0, s.cmp_en};
  assign chan_cur   = {5'h00, s.chan};
  assign any_wr     = wr_in || bit_wr_in;
  assign mode0_wr   = any_wr && (addr_in == MODE0_ADDR);
  assign chan_wr    = any_wr && (addr_in == CHANNEL_ADDR);
  assign mode2_wr   = any_wr && (addr_in == MODE2_ADDR);
  assign rd_result  = rd_in && ((addr_in == RESULT_HIGH_ADDR) || (addr_in == RESULT_LOW_ADDR));
  assign wval_mode0 = wr_in ? wdata_in : merge_bit(mode0_cur, bit_sel_in, bit_val_in);
  assign wval_chan  = wr_in ? wdata_in : merge_bit(chan_cur, bit_sel_in, bit_val_in); // RL11
  assign wval_mode2 = wr_in ? wdata_in : merge_bit({7'h00, s.res8}, bit_sel_in, bit_val_in);
  assign tick       = (s.div_cnt == 3'h0); // RL23
  assign end_now    = (s.phase == PH_FINISH) && tick && (s.step_cnt == 5'h01);
  assign new_high   = s.sar[9:2]; // RL1 RL7
  assign new_low    = s.res8 ? 8'h00 : {s.sar[1:0], 6'h00}; // RL1 RL2 RL6

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.div_cnt = tick ? div_reload(s.fr) : s.div_cnt - 3'h1;

    // Deferred result write lands the cycle after a colliding read
    if (s.pend) begin
      next_s.pend = 1'b0;
      next_s.res_high = s.pend_high; // RL21
      next_s.res_low = s.pend_low;
      next_s.irq = 1'b1;
    end

    case (s.phase)
      PH_IDLE: begin
        next_s.hold = 1'b0;
      end
      PH_SAMPLE: begin
        if (tick) begin
          next_s.step_cnt = s.step_cnt - 5'h01;
          if (s.step_cnt == 5'h01) begin
            next_s.phase = PH_COMPARE; // RL12
            next_s.hold = 1'b1;
            next_s.sar = SAR_FIRST; // RL13
            next_s.bit_pos = 4'h9;
          end
        end
      end
      PH_COMPARE: begin
        if (tick) begin
          // Keep the trial bit when sample reaches the tap, then try the next bit
          next_s.sar[s.bit_pos] = comp_in; // RL13 RL14 RL15
          if (s.bit_pos == (s.res8 ? LAST_BIT_8 : LAST_BIT_10)) begin
            next_s.phase = PH_FINISH;
            next_s.step_cnt = FINISH_CLKS;
          end else begin
            next_s.sar[s.bit_pos - 4'h1] = 1'b1; // RL14
            next_s.bit_pos = s.bit_pos - 4'h1;
          end
        end
      end
      PH_FINISH: begin
        if (tick) begin
          next_s.step_cnt = s.step_cnt - 5'h01;
        end
        if (end_now) begin
          next_s.phase = PH_IDLE;
          next_s.start = 1'b0; // RL17
          next_s.hold = 1'b0;
          if (mode0_wr) begin
            next_s.phase = PH_IDLE; // RL22
          end else if (rd_result) begin
            next_s.pend = 1'b1; // RL21
            next_s.pend_high = new_high;
            next_s.pend_low = new_low;
          end else begin
            next_s.res_high = new_high; // RL15
            next_s.res_low = new_low;
            next_s.irq = 1'b1; // RL16
          end
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase

    // Register writes; the result registers have no write path
    if (mode0_wr) begin
      next_s.fr = {wval_mode0[FR1_BIT], wval_mode0[FR0_BIT]};
      next_s.lv0 = wval_mode0[LV0_BIT];
      next_s.cmp_en = wval_mode0[CMP_EN_BIT];
      if (!wval_mode0[START_BIT]) begin
        // Clearing start aborts any conversion in progress
        next_s.start = 1'b0;
        next_s.phase = PH_IDLE;
        next_s.hold = 1'b0;
      end else if (s.cmp_en && !s.start) begin
        next_s.start = 1'b1; // RL17 RL20
        next_s.phase = PH_SAMPLE;
        next_s.hold = 1'b0;
        next_s.sar = SAR_RESET;
        next_s.step_cnt = wval_mode0[LV0_BIT] ? SAMPLE_SHORT : SAMPLE_LONG;
        next_s.div_cnt = div_reload({wval_mode0[FR1_BIT], wval_mode0[FR0_BIT]});
      end
    end
    if (chan_wr) begin
      next_s.chan = wval_chan[2:0]; // RL8 RL9
    end
    if (mode2_wr) begin
      next_s.res8 = wval_mode2[RES_BIT]; // RL19
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    next_s.rdata = 8'h00;
    if (rd_in) begin
      if (addr_in == RESULT_HIGH_ADDR) begin
        next_s.rdata = s.res_high; // RL3
      end else if (addr_in == RESULT_LOW_ADDR) begin
        next_s.rdata = s.res_low;
      end else if (addr_in == MODE0_ADDR) begin
        next_s.rdata = mode0_cur;
      end else if (addr_in == CHANNEL_ADDR) begin
        next_s.rdata = chan_cur; // RL9
      end else if (addr_in == MODE2_ADDR) begin
        next_s.rdata = {7'h00, s.res8};
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s.phase     <= PH_IDLE;
      s.start     <= 1'b0;
      s.cmp_en    <= 1'b0;
      s.fr        <= 2'h0;
      s.lv0       <= 1'b0;
      s.res8      <= 1'b0;
      s.chan      <= 3'h0; // RL8
      s.res_high  <= REG_RESET; // RL4
      s.res_low   <= REG_RESET;
      s.sar       <= SAR_RESET;
      s.bit_pos   <= 4'h0;
      s.div_cnt   <= 3'h0;
      s.step_cnt  <= 5'h00;
      s.pend      <= 1'b0;
      s.pend_high <= REG_RESET;
      s.pend_low  <= REG_RESET;
      s.irq       <= 1'b0;
      s.hold      <= 1'b0;
      s.rdata     <= REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out              = s.rdata;
  assign conversion_end_irq_out = s.irq;
  assign sample_hold_out        = s.hold;
  assign tap_select_out         = s.sar;
  assign channel_select_out     = s.chan;
  assign comparator_enable_out  = s.cmp_en;
  assign converting_out         = s.start;

  // ==========================================================================
  // Checks
  sequence seq_collide_read;
    end_now && rd_result && !mode0_wr;
  endsequence

  sequence seq_late_commit;
    ##1 s.pend ##1 (conversion_end_irq_out && s.res_high == $past(s.pend_high));
  endsequence

  property p_low_zero;
    @(posedge clk_in) disable iff (sys_rst_in) s.res_low[5:0] == 6'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low result bits 5..0 not zero"); // RL2

  property p_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (end_now && !rd_result && !mode0_wr) |=>
        (conversion_end_irq_out && s.res_high == $past(s.sar[9:2]) && !converting_out);
  endproperty
  a_store: assert property (p_store) else $error("result not latched with request"); // RL16

  property p_read_first;
    @(posedge clk_in) disable iff (sys_rst_in)
      seq_collide_read |-> seq_late_commit and (##1 (!conversion_end_irq_out && rdata_out == $past(s.res_high)));
  endproperty
  a_read_first: assert property (p_read_first) else $error("colliding read did not defer store"); // RL21

  property p_mode_wins;
    @(posedge clk_in) disable iff (sys_rst_in)
      (end_now && mode0_wr && !s.pend) |=> (!conversion_end_irq_out && $stable(s.res_high) && $stable(s.res_low));
  endproperty
  a_mode_wins: assert property (p_mode_wins) else $error("mode write lost to result store"); // RL22

  property p_ignore_start;
    @(posedge clk_in) disable iff (sys_rst_in)
      (mode0_wr && !s.cmp_en && !s.start) |=> !converting_out;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("start taken with comparator off"); // RL20

  property p_first_trial;
    @(posedge clk_in) disable iff (sys_rst_in)
      (s.phase == PH_SAMPLE && next_s.phase == PH_COMPARE) |=> (tap_select_out == 10'h200 && sample_hold_out);
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial not at half tap"); // RL13

  property p_low8;
    @(posedge clk_in) disable iff (sys_rst_in)
      (conversion_end_irq_out && s.res8) |-> s.res_low == 8'h00;
  endproperty
  a_low8: assert property (p_low8) else $error("8-bit low result not zero"); // RL6

  property p_irq_pulse;
    @(posedge clk_in) disable iff (sys_rst_in)
      conversion_end_irq_out |=> !conversion_end_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("end request longer than one cycle"); // RL17

  property p_chan_upper;
    @(posedge clk_in) disable iff (sys_rst_in)
      (rd_in && addr_in == CHANNEL_ADDR) |=> rdata_out[7:3] == 5'h00;
  endproperty
  a_chan_upper: assert property (p_chan_upper) else $error("channel upper bits not zero"); // RL9

  // End of conversion with no bus access in the way
  sequence seq_clean_end;
    end_now && !rd_result && !mode0_wr;
  endsequence

  property p_low10;
    @(posedge clk_in) disable iff (sys_rst_in)
      (seq_clean_end ##0 !s.res8) |=> s.res_low == {$past(s.sar[1:0]), 6'h00};
  endproperty
  a_low10: assert property (p_low10) else $error("10-bit low result bits not stored"); // RL1

  property p_hold_kept;
    @(posedge clk_in) disable iff (sys_rst_in)
      (s.phase == PH_COMPARE || s.phase == PH_FINISH) |-> sample_hold_out;
  endproperty
  a_hold_kept: assert property (p_hold_kept) else $error("sample released during conversion"); // RL12

  property p_start_ends;
    @(posedge clk_in) disable iff (sys_rst_in)
      end_now |=> !converting_out;
  endproperty
  a_start_ends: assert property (p_start_ends) else $error("start bit not cleared at end"); // RL17

  property p_chan_byte;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == CHANNEL_ADDR) |=> channel_select_out == $past(wdata_in[2:0]);
  endproperty
  a_chan_byte: assert property (p_chan_byte) else $error("channel byte write not taken"); // RL8

  property p_res_sel;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == MODE2_ADDR) |=> s.res8 == $past(wdata_in[RES_BIT]);
  endproperty
  a_res_sel: assert property (p_res_sel) else $error("resolution select not taken"); // RL19

endmodule

`default_nettype wire

/* design/sar_adc_pkg.sv */
// Constants, register map and state encodings for the converter control block
// How it works
// RL1: At 10-bit end, upper eight result bits go high, lowest two go low.
// RL2: Low result keeps its two bits on top; lower six bits read zero.
// RL3: Result registers are byte-read only; software writes do not change them.
// RL4: Reset clears both result registers to zero.
// RL5: Software reads the result before writing mode or channel registers.
// RL6: In 8-bit mode the low result reads zero after completion.
// RL7: In 8-bit mode the high result holds the full eight-bit value.
// RL8: Channel register at its own address, resets zero, bits 2..0 choose input.
// RL9: Channel bits 7..3 are written zero and always read zero.
// RL10: Software changes the channel only while no conversion runs.
// RL11: Channel register takes single-bit and whole-byte writes.
// RL12: Conversion samples the channel a fixed time, then holds it.
// RL13: First step sets bit 9, half tap; keep it if input exceeds tap.
// RL14: Second step sets bit 8 at three-quarter or quarter tap per bit 9.
// RL15: Steps repeat down to bit 0 (bit 2 in 8-bit mode); final value latched into the results.
// RL16: End-of-conversion request rises as the result is latched.
// RL17: Each start write gives one conversion; start bit then clears itself.
// RL18: Software sets port direction and analog mode bits before analog use.
// RL19: Resolution select zero means 10-bit, one means 8-bit.
// RL20: Start write while the comparator is disabled is ignored.
// RL21: A result read colliding with the result write wins; write follows.
// RL22: A mode write colliding with the result write wins; no store, no request.
// RL23: One approximation bit per conversion clock from the selected divider.
package sar_adc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [19:0] MODE0_ADDR       = 20'hFFF30;
  localparam logic [19:0] CHANNEL_ADDR     = 20'hFFF31;
  localparam logic [19:0] MODE2_ADDR       = 20'hF0010;
  localparam logic [19:0] RESULT_HIGH_ADDR = 20'hFFF1F;
  localparam logic [19:0] RESULT_LOW_ADDR  = 20'hFFF1E;

  // ==========================================================================
  // Field positions
  localparam int START_BIT  = 7;
  localparam int FR1_BIT    = 4;
  localparam int FR0_BIT    = 3;
  localparam int LV0_BIT    = 1;
  localparam int CMP_EN_BIT = 0;
  localparam int RES_BIT    = 0;

  // ==========================================================================
  // Reset values and first trial value
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [9:0] SAR_RESET  = 10'h000;
  localparam logic [9:0] SAR_FIRST  = 10'h200;

  // ==========================================================================
  // Cycle counts in conversion clocks and last trial bit positions
  localparam logic [4:0] SAMPLE_LONG  = 5'h09;
  localparam logic [4:0] SAMPLE_SHORT = 5'h03;
  localparam logic [4:0] FINISH_CLKS  = 5'h04;
  localparam logic [3:0] LAST_BIT_10  = 4'h0;
  localparam logic [3:0] LAST_BIT_8   = 4'h2;

  typedef enum logic [3:0] {
    PH_IDLE    = 4'b0001,
    PH_SAMPLE  = 4'b0010,
    PH_COMPARE = 4'b0100,
    PH_FINISH  = 4'b1000
  } phase_t;

endpackage

/* tb/sar_analog_model.sv */
// Behavioural sample-hold, tap selector and comparator facing the converter control
`timescale 1ns/1ps
`default_nettype none

module sar_analog_model #(
  parameter logic [79:0] LEVELS = 80'h0
) (
  input  wire logic       clk_in,
  input  wire logic       sample_hold_in,
  input  wire logic       comparator_enable_in,
  input  wire logic [2:0] channel_in,
  input  wire logic [9:0] tap_in,
  output logic            comp_out
);
  // ==========================================================================
  // Held sample and comparator
  logic [9:0] held;

  // Tracks the selected input while sampling, freezes it once hold is raised
  // Every channel is wired as an analog input, its port set up for analog use
  always_ff @(posedge clk_in) begin
    if (!sample_hold_in) begin
      held <= LEVELS[channel_in*10 +: 10];
    end
  end

  // A stopped comparator gives nothing useful, so it shows a pattern that follows the tap
  assign comp_out = comparator_enable_in ? (held >= tap_in) : (^tap_in);
endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sar_adc_pkg::*;
  // ==========================================================================
  // Analog levels per channel, channel 0 in the lowest slice
  localparam logic [79:0] LEVELS = {10'h27B, 10'h0F0, 10'h33C, 10'h1C3,
                                    10'h001, 10'h3FE, 10'h15A, 10'h2A5};
  logic        clk_in;
  logic        sys_rst_in;
  logic [19:0] addr_in;
  logic        wr_in;
  logic [7:0]  wdata_in;
  logic        bit_wr_in;
  logic [2:0]  bit_sel_in;
  logic        bit_val_in;
  logic        rd_in;
  logic        comp;
  logic [7:0]  rdata_out;
  logic        conversion_end_irq_out;
  logic        sample_hold_out;
  logic [9:0]  tap_select_out;
  logic [2:0]  channel_select_out;
  logic        comparator_enable_out;
  logic        converting_out;
  int          n_fail;
  int          checked;
  int          cycles;

  sar_adc_ctrl i_sar_adc_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_in(wr_in),
    .wdata_in(wdata_in), .bit_wr_in(bit_wr_in), .bit_sel_in(bit_sel_in), .bit_val_in(bit_val_in),
    .rd_in(rd_in), .comp_in(comp), .rdata_out(rdata_out), .conversion_end_irq_out(conversion_end_irq_out),
    .sample_hold_out(sample_hold_out), .tap_select_out(tap_select_out),
    .channel_select_out(channel_select_out), .comparator_enable_out(comparator_enable_out),
    .converting_out(converting_out));

  sar_analog_model #(.LEVELS(LEVELS)) i_sar_analog_model (.clk_in(clk_in), .sample_hold_in(sample_hold_out),
    .comparator_enable_in(comparator_enable_out), .channel_in(channel_select_out),
    .tap_in(tap_select_out), .comp_out(comp));

  // ==========================================================================
  // Clock, reset and run limit
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic results();
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(negedge clk_in);
    wr_in = 1'b0;
  endtask

  task automatic bw(input logic [19:0] a, input logic [2:0] sel, input logic val);
    @(negedge clk_in);
    addr_in = a;
    bit_sel_in = sel;
    bit_val_in = val;
    bit_wr_in = 1'b1;
    @(negedge clk_in);
    bit_wr_in = 1'b0;
  endtask

  // Read data is taken at the cycle after the strobe, the only cycle it stands
  task automatic rd(input logic [19:0] a, input logic [7:0] exp, input string name);
    @(negedge clk_in);
    addr_in = a;
    rd_in = 1'b1;
    @(negedge clk_in);
    rd_in = 1'b0;
    check(name, {2'b00, rdata_out}, {2'b00, exp});
  endtask

  // Result is read before the next setup write touches the mode registers
  task automatic convert(input logic [2:0] ch, input logic [1:0] fr, input logic lv, input logic res8);
    logic [9:0] v;
    logic [7:0] m;
    int         k;
    int         n_samp;
    int         n_hold;
    v = LEVELS[ch*10 +: 10];
    m = {3'b000, fr, 1'b0, lv, 1'b1};
    n_samp = 0;
    n_hold = 0;
    wr(CHANNEL_ADDR, {5'h00, ch});
    wr(MODE2_ADDR, {7'h00, res8});
    wr(MODE0_ADDR, m);
    wr(MODE0_ADDR, m | 8'h80);
    check("converting", {9'h000, converting_out}, 10'h001);
    check("cmp_enable_pin", {9'h000, comparator_enable_out}, 10'h001);
    k = 0;
    while (conversion_end_irq_out !== 1'b1 && k < 2000) begin
      if (converting_out === 1'b1 && sample_hold_out === 1'b0) n_samp++;
      if (sample_hold_out === 1'b1) n_hold++;
      @(negedge clk_in);
      k++;
    end
    check("irq", {9'h000, conversion_end_irq_out}, 10'h001);
    check("hold_released", {9'h000, sample_hold_out}, 10'h000);
    k = (lv ? SAMPLE_SHORT : SAMPLE_LONG) * (8 >> fr);
    check("sample_cycles", n_samp[9:0], k[9:0]);
    k = ((res8 ? 8 : 10) + FINISH_CLKS) * (8 >> fr);
    check("hold_cycles", n_hold[9:0], k[9:0]);
    @(negedge clk_in);
    check("irq_pulse", {9'h000, conversion_end_irq_out}, 10'h000);
    check("start_clear", {9'h000, converting_out}, 10'h000);
    rd(RESULT_HIGH_ADDR, v[9:2], "result_high");
    rd(RESULT_LOW_ADDR, res8 ? 8'h00 : {v[1:0], 6'h00}, "result_low");
  endtask

  // Fastest divider and short sample, 10-bit; its last edge, 17 cycles after the start, meets a read or a mode write
  task automatic collide(input logic use_rd, input logic [2:0] ch, input logic [7:0] old);
    int n;
    n = 0;
    wr(CHANNEL_ADDR, {5'h00, ch});
    wr(MODE0_ADDR, 8'h1B);
    wr(MODE0_ADDR, 8'h9B);
    repeat (15) @(negedge clk_in);
    if (use_rd) begin
      rd(RESULT_HIGH_ADDR, old, "collide_old");
    end else begin
      wr(MODE0_ADDR, 8'h1B);
    end
    repeat (4) begin
      @(negedge clk_in);
      if (conversion_end_irq_out === 1'b1) n++;
    end
    check("collide_irq", n[9:0], {9'h000, use_rd});
    check("collide_idle", {9'h000, converting_out}, 10'h000);
    rd(RESULT_HIGH_ADDR, use_rd ? LEVELS[ch*10 + 2 +: 8] : old, "collide_high");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    sys_rst_in = 1'b1;
    addr_in = 20'h00000;
    wr_in = 1'b0;
    wdata_in = 8'h00;
    bit_wr_in = 1'b0;
    bit_sel_in = 3'h0;
    bit_val_in = 1'b0;
    rd_in = 1'b0;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    do_reset();
    rd(RESULT_HIGH_ADDR, 8'h00, "high_reset");
    rd(RESULT_LOW_ADDR, 8'h00, "low_reset");
    rd(CHANNEL_ADDR, 8'h00, "channel_reset");
    wr(MODE0_ADDR, 8'h80);
    @(negedge clk_in);
    check("start_refused", {9'h000, converting_out}, 10'h000);
    for (int i = 0; i < 8; i++) begin
      wr(CHANNEL_ADDR, i[7:0]);
      check("channel_pins", {7'h00, channel_select_out}, i[9:0]);
    end
    wr(CHANNEL_ADDR, 8'hFF);
    rd(CHANNEL_ADDR, 8'h07, "channel_fixed");
    bw(CHANNEL_ADDR, 3'h1, 1'b0);
    bw(CHANNEL_ADDR, 3'h5, 1'b1);
    rd(CHANNEL_ADDR, 8'h05, "channel_bit");
    check("channel_bit_pins", {7'h00, channel_select_out}, 10'h005);
    wr(RESULT_HIGH_ADDR, 8'h55);
    wr(RESULT_LOW_ADDR, 8'hC0);
    rd(RESULT_HIGH_ADDR, 8'h00, "high_ro");
    rd(RESULT_LOW_ADDR, 8'h00, "low_ro");
    for (int i = 0; i < 8; i++) begin
      convert(i[2:0], i[1:0], i[2], (i == 3 || i == 6));
    end
    wr(MODE0_ADDR, 8'h19);
    wr(MODE0_ADDR, 8'h99);
    repeat (5) @(negedge clk_in);
    wr(MODE0_ADDR, 8'h19);
    n = 0;
    repeat (300) begin
      @(negedge clk_in);
      if (conversion_end_irq_out === 1'b1) n++;
    end
    check("abort_irq", n[9:0], 10'h000);
    check("abort_idle", {9'h000, converting_out}, 10'h000);
    rd(RESULT_HIGH_ADDR, LEVELS[79:72], "abort_keep");
    collide(1'b1, 3'h5, LEVELS[79:72]);
    collide(1'b0, 3'h6, LEVELS[59:52]);
    do_reset();
    rd(RESULT_HIGH_ADDR, 8'h00, "high_rereset");
    rd(RESULT_LOW_ADDR, 8'h00, "low_rereset");
    results();
  end
endmodule

`default_nettype wire
